// File: hw/npm_top.sv
// Purpose: Command control of the navigation position interface.
// Assumes: Host command bytes and parser results arrive on mclk.
// Notes:   Sentence field parsing lives outside; this block gates and keeps its results.
`timescale 1ns/1ps
`include "npm_consts.svh"
module npm_top #(
  parameter int SECOND_CYCLES = `NPM_SECOND_CYC,
  parameter int LED_CYCLES    = `NPM_LED_CYC
) (
  // Clock and reset.
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  // Host command bytes.
  input  wire logic [7:0]             cmd_char,
  input  wire logic                   cmd_strobe,
  input  wire logic                   host_serial,
  // Navigation link and parser.
  input  wire logic                   nav_rx_signal,
  output logic      [7:0]             nav_byte,
  output logic                        nav_byte_valid,
  input  wire logic                   fix_ok,
  input  wire npm_pkg::npm_sent_type  fix_kind,
  input  wire npm_pkg::npm_pos_type   fix_pos,
  input  wire npm_pkg::npm_stamp_type fix_stamp,
  // Instrument records.
  input  wire logic                   scan_strobe,
  output logic                        pos_attach,
  output npm_pkg::npm_pos_type        pos_attach_data,
  // Text output.
  output logic      [7:0]             txt_byte,
  output logic                        txt_valid,
  output logic                        txt_parallel,
  input  wire logic                   txt_ready,
  // Front panel and status.
  output logic                        nav_led,
  output logic                        nav_rate_high
);
  localparam int LB = `NPM_LINE_BYTES;
  logic [103:0]          cmd_buf_reg;
  logic [3:0]            cmd_len_reg;
  logic                  append_en_reg;
  logic                  have_fix_reg;
  npm_pkg::npm_pos_type  pos_reg;
  npm_pkg::npm_stamp_type stamp_reg;
  npm_pkg::npm_sent_type kind_reg;
  logic [31:0]           sec_cnt_reg;
  logic                  sec_due_reg;
  logic [31:0]           led_cnt_reg;
  npm_pkg::npm_dump_type dump_reg;
  logic [LB*8-1:0]       line_reg;
  logic [4:0]            len_reg;
  logic                  eol, accepted, send, serial_attach_ok;
  logic                  cr, m_on, m_off, m_dump_ser, m_dump_par, m_status, m_lo, m_hi;

  // Fold lower-case letters onto upper case.
  function automatic logic [7:0] upcase(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7A) ? c - 8'h20 : c;
  endfunction : upcase

  // Five sentence kinds carry a usable position.
  function automatic logic nav_kind(input npm_pkg::npm_sent_type k);
    return k inside {npm_pkg::NPM_SENT_GGA, npm_pkg::NPM_SENT_GLL, npm_pkg::NPM_SENT_RMA,
                     npm_pkg::NPM_SENT_RMC, npm_pkg::NPM_SENT_TRF};
  endfunction : nav_kind

  // Decimal digit and two-digit ASCII forms of a binary count.
  function automatic logic [7:0] dig(input logic [7:0] v);
    return 8'h30 + v;
  endfunction : dig

  function automatic logic [15:0] two(input logic [7:0] v);
    return {dig(8'(v / 8'd10)), dig(8'(v % 8'd10))};
  endfunction : two

  // Receiver sits on the link; the parser sees every good byte.
  npm_uart_rx #(.CW(12)) u_rx (
    .mclk       (mclk),
    .resetn     (resetn),
    .rx_pin     (nav_rx_signal),
    .bit_cycles (nav_rate_high ? 12'(`NPM_BIT_HIGH) : 12'(`NPM_BIT_LOW)),
    .rx_byte    (nav_byte),
    .rx_valid   (nav_byte_valid)
  );

  // Command match on carriage return; the buffer already holds upper case.
  always_comb begin
    cr    = cmd_strobe && (cmd_char == `NPM_CHAR_CR);
    m_on       = cr && cmd_len_reg == 4'd2 && cmd_buf_reg[15:0] == `NPM_CMD_APPEND_ON;
    m_off      = cr && cmd_len_reg == 4'd2 && cmd_buf_reg[15:0] == `NPM_CMD_APPEND_OFF;
    m_dump_ser = cr && cmd_len_reg == 4'd3 && cmd_buf_reg[23:0] == `NPM_CMD_DUMP_SER;
    m_dump_par = cr && cmd_len_reg == 4'd3 && cmd_buf_reg[23:0] == `NPM_CMD_DUMP_PAR;
    m_status   = cr && cmd_len_reg == 4'd2 && cmd_buf_reg[15:0] == `NPM_CMD_STATUS;
    m_lo       = cr && cmd_len_reg == 4'd13 && cmd_buf_reg == `NPM_CMD_RATE_LOW;
    m_hi       = cr && cmd_len_reg == 4'd13 && cmd_buf_reg == `NPM_CMD_RATE_HIGH;
  end

  // Command line collector; the length saturates so overlong lines never match.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cmd_buf_reg <= '0;
      cmd_len_reg <= 4'h0;
    end else if (cmd_strobe && cmd_char == `NPM_CHAR_CR) begin
      cmd_len_reg <= 4'h0;
    end else if (cmd_strobe && cmd_char != `NPM_CHAR_LF) begin
      cmd_buf_reg <= {cmd_buf_reg[95:0], upcase(cmd_char)};
      cmd_len_reg <= (cmd_len_reg == 4'hF) ? 4'hF : cmd_len_reg + 4'h1;
    end
  end

  // Rate select; unknown rates leave the setting alone.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      nav_rate_high <= `NPM_RATE_RESET;
    end else if (m_lo || m_hi) begin
      nav_rate_high <= m_hi;
    end
  end

  // Append enable: plain flops with no path to any saved configuration.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      append_en_reg <= `NPM_APPEND_RESET;
    end else if (m_on || m_off) begin
      append_en_reg <= m_on;
    end
  end

  // Keep the latest accepted fix; it is reused until a newer one lands.
  assign accepted = fix_ok && nav_kind(fix_kind);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pos_reg      <= '0;
      stamp_reg    <= '0;
      kind_reg     <= npm_pkg::NPM_SENT_NONE;
      have_fix_reg <= 1'b0;
    end else if (accepted) begin
      pos_reg      <= fix_pos;
      stamp_reg    <= fix_stamp;
      kind_reg     <= fix_kind;
      have_fix_reg <= 1'b1;
    end
  end

  // Indicator stretched so a person can see each decode.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      led_cnt_reg <= 32'h0;
      nav_led     <= 1'b0;
    end else if (accepted) begin
      led_cnt_reg <= 32'(LED_CYCLES - 1);
      nav_led     <= 1'b1;
    end else begin
      led_cnt_reg <= (led_cnt_reg == 32'h0) ? 32'h0 : led_cnt_reg - 32'h1;
      nav_led     <= (led_cnt_reg != 32'h0);
    end
  end

  // One-second ticker; a tick in the attach cycle re-arms instead of being lost.
  assign serial_attach_ok = sec_due_reg && scan_strobe && append_en_reg && have_fix_reg;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sec_cnt_reg <= 32'h0;
      sec_due_reg <= 1'b1;
    end else begin
      sec_cnt_reg <= (sec_cnt_reg == 32'(SECOND_CYCLES - 1)) ? 32'h0 : sec_cnt_reg + 32'h1;
      if (sec_cnt_reg == 32'(SECOND_CYCLES - 1)) begin
        sec_due_reg <= 1'b1;
      end else if (host_serial && serial_attach_ok) begin
        sec_due_reg <= 1'b0;
      end
    end
  end

  // Attach the held position to each record, rate limited on a serial link.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pos_attach      <= 1'b0;
      pos_attach_data <= '0;
    end else begin
      pos_attach <= scan_strobe && append_en_reg && have_fix_reg
                    && (!host_serial || sec_due_reg);
      if (scan_strobe) begin
        pos_attach_data <= pos_reg;
      end
    end
  end

  // Text lines, left aligned in a 24-byte buffer.
  assign eol  = (len_reg == 5'd0) && !txt_valid;
  assign send = (len_reg != 5'd0) && (!txt_valid || txt_ready);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dump_reg     <= npm_pkg::NPM_DUMP_IDLE;
      line_reg     <= '0;
      len_reg      <= 5'd0;
      txt_parallel <= 1'b0;
    end else if (send) begin
      line_reg <= {line_reg[LB*8-9:0], 8'h00};
      len_reg  <= len_reg - 5'd1;
    end else if (eol) begin
      unique case (dump_reg)
        npm_pkg::NPM_DUMP_IDLE: begin
          if (m_dump_ser || m_dump_par) begin
            dump_reg     <= npm_pkg::NPM_DUMP_LAT;
            txt_parallel <= m_dump_par;
            len_reg      <= 5'd16;
            line_reg     <= {"LAT ", two(8'(pos_reg.lat_deg)), " ", two(8'(pos_reg.lat_min)),
                             ".", two(8'(pos_reg.lat_hund)), " ",
                             pos_reg.lat_south ? "S" : "N", `NPM_CHAR_CR, `NPM_CHAR_LF,
                             64'h0};
          end else if (m_status) begin
            dump_reg     <= npm_pkg::NPM_DUMP_BAUD;
            txt_parallel <= 1'b0;
            len_reg      <= 5'd23;
            line_reg     <= {"NMEA baud rate = ", nav_rate_high ? "9600" : "4800",
                             `NPM_CHAR_CR, `NPM_CHAR_LF, 8'h00};
          end
        end
        npm_pkg::NPM_DUMP_LAT: begin
          dump_reg <= npm_pkg::NPM_DUMP_LON;
          len_reg  <= 5'd17;
          line_reg <= {"LON ", dig(8'(pos_reg.lon_deg / 8'd100)),
                       two(8'(pos_reg.lon_deg % 8'd100)), " ", two(8'(pos_reg.lon_min)),
                       ".", two(8'(pos_reg.lon_hund)), " ", pos_reg.lon_west ? "W" : "E",
                       `NPM_CHAR_CR, `NPM_CHAR_LF, 56'h0};
        end
        npm_pkg::NPM_DUMP_LON: begin
          if (kind_reg == npm_pkg::NPM_SENT_RMC) begin
            dump_reg <= npm_pkg::NPM_DUMP_DATE;
            len_reg  <= 5'd15;
            line_reg <= {two(8'(stamp_reg.day)), two(8'(stamp_reg.mon)),
                         two(8'(stamp_reg.year)), " ", two(8'(stamp_reg.hour)),
                         two(8'(stamp_reg.minute)), two(8'(stamp_reg.sec)),
                         `NPM_CHAR_CR, `NPM_CHAR_LF, 72'h0};
          end else begin
            dump_reg <= npm_pkg::NPM_DUMP_IDLE;
          end
        end
        npm_pkg::NPM_DUMP_DATE: dump_reg <= npm_pkg::NPM_DUMP_IDLE;
        npm_pkg::NPM_DUMP_BAUD: dump_reg <= npm_pkg::NPM_DUMP_IDLE;
      endcase
    end
  end

  // Byte presenter holds each byte until the sink takes it.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      txt_byte  <= 8'h00;
      txt_valid <= 1'b0;
    end else if (send) begin
      txt_byte  <= line_reg[LB*8-1 -: 8];
      txt_valid <= 1'b1;
    end else if (txt_ready) begin
      txt_valid <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence dump_asked;
    (m_dump_ser || m_dump_par) && eol && dump_reg == npm_pkg::NPM_DUMP_IDLE;
  endsequence
  sequence lat_loaded;
    dump_reg == npm_pkg::NPM_DUMP_LAT && len_reg == 5'd16;
  endsequence
  AST_DUMP_START: assert property (dump_asked |=> lat_loaded)
    else $error("dump did not start with the latitude line");
  AST_DUMP_PORT: assert property (dump_asked |=> txt_parallel == $past(m_dump_par))
    else $error("dump sent to the wrong port");
  AST_RMC_DATE: assert property (dump_reg == npm_pkg::NPM_DUMP_LON && eol
      && kind_reg == npm_pkg::NPM_SENT_RMC |=> dump_reg == npm_pkg::NPM_DUMP_DATE)
    else $error("date line missing after RMC");
  AST_BAUD_KEEP: assert property (cr && !m_lo && !m_hi |=> $stable(nav_rate_high))
    else $error("rate changed by an unknown value");
  AST_APPEND_ON: assert property (m_on |=> append_en_reg ##1 append_en_reg || m_off)
    else $error("append enable not set");
  AST_APPEND_HOLD: assert property (!m_on && !m_off |=> $stable(append_en_reg))
    else $error("append enable changed without a command");
  AST_LED_PULSE: assert property (accepted |=> nav_led)
    else $error("indicator missed a decode");
  AST_LED_QUIET: assert property (!nav_led && led_cnt_reg == 32'h0 && !accepted
      |=> !nav_led)
    else $error("indicator lit without a decode");
  AST_POS_HOLD: assert property (!accepted |=> $stable(pos_reg))
    else $error("held position changed without a decode");
  AST_SERIAL_LIMIT: assert property (pos_attach && host_serial && $past(host_serial)
      && $past(sec_cnt_reg) != 32'(SECOND_CYCLES - 1) |=> !sec_due_reg || !pos_attach)
    else $error("serial attach repeated inside one second");
endmodule : npm_top

// File: inc/npm_consts.svh
// Purpose: Constants of the navigation position merge control block.
// Assumes: mclk at 10 MHz, synchronous active-low reset.
// Notes:   What this block does is listed below, one line each.
// What this block does
// - A rate command selects 4800 or 9600 baud for the navigation link; any other value is ignored.
// - A position dump prints latitude then longitude as degrees, decimal minutes and hemisphere.
// - When the last decoded sentence was the GPS recommended minimum, a date and time line follows.
// - Each of two dump commands sends exactly one scan of text, one to the serial and one to the parallel port.
// - Append with Y attaches the position to every outgoing record, or at most one per second on a serial host link; with N it stops.
// - The append enable lives only in volatile flops and is never saved.
// - The append enable holds its value until reset or a new append command.
// - The navigation indicator pulses once per successfully decoded sentence and never on a failure.
// - The status command prints a line with the selected navigation baud rate.
// - Five sentence types are decoded with no host selection.
// - The last decoded position is repeated on every attach until a newer one arrives.
// - On a serial host link the position is attached at most once per second.
// - Command letters are accepted in either case.
`ifndef NPM_CONSTS_SVH
`define NPM_CONSTS_SVH
`define NPM_CLK_HZ      10000000
`define NPM_BAUD_LOW    4800
`define NPM_BAUD_HIGH   9600
`define NPM_BIT_LOW     (`NPM_CLK_HZ / `NPM_BAUD_LOW)
`define NPM_BIT_HIGH    (`NPM_CLK_HZ / `NPM_BAUD_HIGH)
`define NPM_SECOND_S    1
`define NPM_SECOND_CYC  (`NPM_SECOND_S * `NPM_CLK_HZ)
`define NPM_LED_MS      50
`define NPM_LED_CYC     (`NPM_LED_MS * (`NPM_CLK_HZ / 1000))
`define NPM_RATE_RESET  1'b0
`define NPM_APPEND_RESET 1'b0
`define NPM_CHAR_CR     8'h0D
`define NPM_CHAR_LF     8'h0A
`define NPM_LINE_BYTES  24
// Command texts in upper-case ASCII; the collector folds case before it compares.
`define NPM_CMD_APPEND_ON   16'h4E59
`define NPM_CMD_APPEND_OFF  16'h4E4E
`define NPM_CMD_DUMP_SER    24'h4E5352
`define NPM_CMD_DUMP_PAR    24'h4E5349
`define NPM_CMD_STATUS      16'h4453
`define NPM_CMD_RATE_PREFIX 72'h4E4D4541424155443D
`define NPM_CMD_RATE_LOW    {`NPM_CMD_RATE_PREFIX, "4800"}
`define NPM_CMD_RATE_HIGH   {`NPM_CMD_RATE_PREFIX, "9600"}
`endif

// File: inc/npm_pkg.sv
// Purpose: Types shared by the navigation position merge control files.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Binary fields are plain counts, not BCD.
package npm_pkg;
  // Sentence kinds reported by the sentence parser.
  typedef enum logic [2:0] {
    NPM_SENT_NONE = 3'h0,
    NPM_SENT_GGA  = 3'h1,
    NPM_SENT_GLL  = 3'h2,
    NPM_SENT_RMA  = 3'h3,
    NPM_SENT_RMC  = 3'h4,
    NPM_SENT_TRF  = 3'h5
  } npm_sent_type;

  // Decoded position.
  typedef struct packed {
    logic [6:0] lat_deg;
    logic [5:0] lat_min;
    logic [6:0] lat_hund;
    logic       lat_south;
    logic [7:0] lon_deg;
    logic [5:0] lon_min;
    logic [6:0] lon_hund;
    logic       lon_west;
  } npm_pos_type;

  // Date and time of a fix.
  typedef struct packed {
    logic [4:0] day;
    logic [3:0] mon;
    logic [6:0] year;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] sec;
  } npm_stamp_type;

  // Text dump sequencer states.
  typedef enum logic [4:0] {
    NPM_DUMP_IDLE = 5'b00001,
    NPM_DUMP_LAT  = 5'b00010,
    NPM_DUMP_LON  = 5'b00100,
    NPM_DUMP_DATE = 5'b01000,
    NPM_DUMP_BAUD = 5'b10000
  } npm_dump_type;

  // Receiver states.
  typedef enum logic [3:0] {
    NPM_RX_IDLE  = 4'b0001,
    NPM_RX_START = 4'b0010,
    NPM_RX_DATA  = 4'b0100,
    NPM_RX_STOP  = 4'b1000
  } npm_rx_type;
endpackage : npm_pkg

// File: hw/npm_uart_rx.sv
// Purpose: Serial receiver for the navigation link.
// Assumes: Idle-high line, bit time given in mclk cycles.
// Notes:   A byte with a bad stop bit is dropped.
`timescale 1ns/1ps
module npm_uart_rx #(
  parameter int CW = 12
) (
  // Clock and reset.
  input  wire logic          mclk,
  input  wire logic          resetn,
  // Line and rate.
  input  wire logic          rx_pin,
  input  wire logic [CW-1:0] bit_cycles,
  // Received byte.
  output logic      [7:0]    rx_byte,
  output logic               rx_valid
);
  logic              sync1_reg;
  logic              sync2_reg;
  npm_pkg::npm_rx_type state_reg;
  logic [CW-1:0]     cnt_reg;
  logic [2:0]        bit_reg;
  logic [7:0]        shift_reg;

  // Two-stage synchroniser; only sync2_reg is looked at.
  always_ff @(posedge mclk) begin
    sync1_reg <= resetn ? rx_pin : 1'b1;
    sync2_reg <= resetn ? sync1_reg : 1'b1;
  end

  // Framing: start bit checked at mid-bit, eight data bits LSB first, one stop bit.
  always_ff @(posedge mclk) begin
    rx_valid <= 1'b0;
    if (!resetn) begin
      state_reg <= npm_pkg::NPM_RX_IDLE;
      cnt_reg   <= '0;
      bit_reg   <= 3'h0;
      shift_reg <= 8'h00;
      rx_byte   <= 8'h00;
    end else begin
      unique case (state_reg)
        npm_pkg::NPM_RX_IDLE: begin
          if (!sync2_reg) begin
            state_reg <= npm_pkg::NPM_RX_START;
            cnt_reg   <= bit_cycles >> 1;
          end
        end
        npm_pkg::NPM_RX_START: begin
          if (cnt_reg == '0) begin
            state_reg <= sync2_reg ? npm_pkg::NPM_RX_IDLE : npm_pkg::NPM_RX_DATA;
            cnt_reg   <= bit_cycles - 1'b1;
            bit_reg   <= 3'h0;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        npm_pkg::NPM_RX_DATA: begin
          if (cnt_reg == '0) begin
            shift_reg <= {sync2_reg, shift_reg[7:1]};
            cnt_reg   <= bit_cycles - 1'b1;
            bit_reg   <= bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              state_reg <= npm_pkg::NPM_RX_STOP;
            end
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        npm_pkg::NPM_RX_STOP: begin
          if (cnt_reg == '0) begin
            // A wrong sender rate shows up here as a lost stop bit.
            rx_valid  <= sync2_reg;
            rx_byte   <= shift_reg;
            state_reg <= npm_pkg::NPM_RX_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_RX_ONE_PULSE: assert property (rx_valid |=> !rx_valid)
    else $error("receiver valid longer than one cycle");
endmodule : npm_uart_rx

// File: bench/npm_nav_model.sv
// Purpose: Behavioural navigation device that sends framed bytes on the nav link.
// Assumes: The bench hands over the bit time in mclk cycles.
// Notes:   The line idles high between frames, as an unloaded serial output does.
`timescale 1ns/1ps
module npm_nav_model (
  // Clock.
  input  wire logic mclk,
  // Serial line towards the block.
  output logic      line
);
  // The line starts idle so the receiver sees no false start bit at reset.
  initial line = 1'b1;

  // One start bit, eight data bits with the least significant first, one stop bit.
  task automatic send_byte(input logic [7:0] data, input int bit_cyc);
    logic [9:0] frame;
    frame = {1'b1, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      line <= frame[i];
      repeat (bit_cyc - 1) @(posedge mclk);
    end
  endtask : send_byte
endmodule : npm_nav_model

// File: bench/tb_top.sv
// Purpose: Self-checking bench of the navigation position merge control block.
// Assumes: Short second and indicator counts are set through parameters.
// Notes:   The text sink stalls every fourth cycle to exercise the hold of text bytes.
`timescale 1ns/1ps
`include "npm_consts.svh"
`define CHK(nm, ex, got) begin \
  checks_done++; \
  if ((got) !== (ex)) begin \
    bad_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
  end \
end
module tb_top;
  // ********************************************************************
  // Signals and instances
  // ********************************************************************
  localparam int SEC_C = 200;
  localparam int LED_C = 10;
  typedef struct {string cmd; logic rate; logic app;} npm_row_type;
  logic                  mclk, resetn, cmd_strobe, host_serial, nav_line, fix_ok;
  logic                  scan_strobe, txt_ready, pos_attach, txt_valid, txt_parallel;
  logic                  nav_led, nav_rate_high, nav_byte_valid;
  logic [7:0]            cmd_char, nav_byte, txt_byte;
  npm_pkg::npm_sent_type fix_kind;
  npm_pkg::npm_pos_type  fix_pos, pos_attach_data;
  npm_pkg::npm_stamp_type fix_stamp;
  int                    bad_count, checks_done, cyc_count;
  string                 lat_s, lon_s;
  npm_row_type           rows[7] = '{'{string'(`NPM_CMD_APPEND_ON), 1'h0, 1'h1},
    '{string'(`NPM_CMD_RATE_HIGH), 1'h1, 1'h1},
    '{lc({string'(`NPM_CMD_RATE_PREFIX), "1234"}, 0), 1'h1, 1'h1},
    '{lc(string'(`NPM_CMD_APPEND_OFF), 0), 1'h1, 1'h0},
    '{lc(string'(`NPM_CMD_RATE_LOW), 5), 1'h0, 1'h0},
    '{"Nq", 1'h0, 1'h0}, '{lc(string'(`NPM_CMD_APPEND_ON), 0), 1'h0, 1'h1}};

  npm_top #(.SECOND_CYCLES(SEC_C), .LED_CYCLES(LED_C)) npm_top_inst (
    .mclk(mclk), .resetn(resetn), .cmd_char(cmd_char), .cmd_strobe(cmd_strobe),
    .host_serial(host_serial), .nav_rx_signal(nav_line), .nav_byte(nav_byte),
    .nav_byte_valid(nav_byte_valid), .fix_ok(fix_ok), .fix_kind(fix_kind),
    .fix_pos(fix_pos), .fix_stamp(fix_stamp), .scan_strobe(scan_strobe),
    .pos_attach(pos_attach), .pos_attach_data(pos_attach_data), .txt_byte(txt_byte),
    .txt_valid(txt_valid), .txt_parallel(txt_parallel), .txt_ready(txt_ready),
    .nav_led(nav_led), .nav_rate_high(nav_rate_high));
  npm_nav_model npm_nav_model_inst (.mclk(mclk), .line(nav_line));

  // ********************************************************************
  // Clock, sink and timeout
  // ********************************************************************
  // The clock runs at 10 MHz.
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // The sink refuses one cycle in four, so a byte must stand until taken.
  always @(posedge mclk) begin
    cyc_count <= cyc_count + 1;
    txt_ready <= (cyc_count % 4 != 2);
    if (cyc_count == 60000) begin
      bad_count++;
      end_of_test();
    end
  end

  // ********************************************************************
  // Tasks
  // ********************************************************************
  // Lower-cases a command text from the given index on, to exercise case folding.
  function automatic string lc(input string s, input int from);
    string t;
    t = s.substr(from, s.len() - 1);
    return {s.substr(0, from - 1), t.tolower()};
  endfunction : lc
  // Characters go back to back, the carriage return closes the command.
  // It returns at the edge that takes the carriage return, so a dump is not missed.
  task automatic send_cmd(input string s);
    for (int i = 0; i <= s.len(); i++) begin
      @(posedge mclk);
      cmd_char <= (i == s.len()) ? 8'h0D : s[i];
      cmd_strobe <= 1'b1;
    end
    @(posedge mclk);
    cmd_strobe <= 1'b0;
  endtask : send_cmd
  // A fix pulse of the given kind; the indicator high time is counted.
  task automatic fix(input npm_pkg::npm_sent_type k, input int exp_led);
    int n;
    n = 0;
    @(posedge mclk);
    fix_kind <= k;
    fix_ok <= 1'b1;
    @(posedge mclk);
    fix_ok <= 1'b0;
    repeat (LED_C + 15) begin
      #1 n += (nav_led === 1'b1);
      @(posedge mclk);
    end
    `CHK("nav_led cycles", exp_led, n)
  endtask : fix
  // One instrument record; the attach pulse is counted over three cycles.
  task automatic scan(input int exp);
    int n;
    npm_pkg::npm_pos_type got;
    n = 0;
    got = '0;
    @(posedge mclk);
    scan_strobe <= 1'b1;
    @(posedge mclk);
    scan_strobe <= 1'b0;
    repeat (3) begin
      #1 if (pos_attach === 1'b1) begin
        n++;
        got = pos_attach_data;
      end
      @(posedge mclk);
    end
    `CHK("pos_attach", exp, n)
    if (exp == 1) `CHK("pos_attach_data", fix_pos, got)
  endtask : scan
  // Each expected text byte must be taken on the port given.
  task automatic collect(input string s, input logic par);
    int k;
    for (int i = 0; i < s.len(); i++) begin
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (!(txt_valid === 1'b1 && txt_ready === 1'b1) && k < 300);
      `CHK("txt_byte", s[i], txt_byte)
      `CHK("txt_parallel", par, txt_parallel)
    end
    k = 0;
    repeat (40) begin
      #1 k += (txt_valid === 1'b1);
      @(posedge mclk);
    end
    `CHK("extra text bytes", 0, k)
  endtask : collect
  // A byte crosses the nav link at the bit time given.
  task automatic nav_send(input logic [7:0] b, input int bitc);
    int k;
    k = 0;
    fork
      npm_nav_model_inst.send_byte(b, bitc);
    join_none
    do begin
      @(posedge mclk);
      #1 k++;
    end while (nav_byte_valid !== 1'b1 && k < 25000);
    `CHK("nav_byte", b, nav_byte)
    wait fork;
  endtask : nav_send
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  // Fixes first, then the rows, the dumps, the rate limit, the link and a late reset.
  initial begin
    {resetn, cmd_strobe, host_serial, fix_ok, scan_strobe} = '0;
    {cmd_char, bad_count, checks_done} = '0;
    fix_kind = npm_pkg::NPM_SENT_NONE;
    fix_pos = '{7'h2F, 6'h25, 7'h33, 1'h0, 8'h7A, 6'h09, 7'h29, 1'h1};
    fix_stamp = '{5'h0C, 4'h07, 7'h18, 5'h0D, 6'h2D, 6'h09};
    lat_s = $sformatf("LAT %02d %02d.%02d N\015\012", fix_pos.lat_deg, fix_pos.lat_min,
                      fix_pos.lat_hund);
    lon_s = $sformatf("LON %03d %02d.%02d W\015\012", fix_pos.lon_deg, fix_pos.lon_min,
                      fix_pos.lon_hund);
    repeat (6) @(posedge mclk);
    `CHK("nav_rate_high", 1'b0, nav_rate_high)
    `CHK("txt_valid", 1'b0, txt_valid)
    resetn <= 1'b1;
    fix(npm_pkg::NPM_SENT_NONE, 0);
    scan(0);
    for (int k = 1; k <= 5; k++) fix(npm_pkg::npm_sent_type'(k), LED_C);
    foreach (rows[r]) begin
      send_cmd(rows[r].cmd);
      repeat (3) @(posedge mclk);
      `CHK("nav_rate_high", rows[r].rate, nav_rate_high)
      scan(rows[r].app);
    end
    send_cmd(string'(`NPM_CMD_DUMP_SER));
    collect({lat_s, lon_s}, 1'b0);
    fix(npm_pkg::NPM_SENT_RMC, LED_C);
    send_cmd(lc(string'(`NPM_CMD_DUMP_PAR), 0));
    collect({lat_s, lon_s, $sformatf("%02d%02d%02d %02d%02d%02d\015\012", fix_stamp.day,
             fix_stamp.mon, fix_stamp.year, fix_stamp.hour, fix_stamp.minute,
             fix_stamp.sec)}, 1'b1);
    send_cmd(lc(string'(`NPM_CMD_STATUS), 0));
    collect($sformatf("NMEA baud rate = %0d\015\012", `NPM_BAUD_LOW), 1'b0);
    host_serial <= 1'b1;
    repeat (SEC_C + 10) @(posedge mclk);
    scan(1);
    scan(0);
    repeat (SEC_C + 10) @(posedge mclk);
    scan(1);
    nav_send(8'hC1, `NPM_BIT_LOW);
    send_cmd(string'(`NPM_CMD_RATE_HIGH));
    nav_send(8'h3A, `NPM_BIT_HIGH);
    send_cmd(string'(`NPM_CMD_RATE_HIGH));
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    `CHK("nav_rate_high", 1'b0, nav_rate_high)
    host_serial <= 1'b0;
    fix(npm_pkg::NPM_SENT_GGA, LED_C);
    scan(0);
    end_of_test();
  end
endmodule : tb_top
